// [relay_output.v]
// Relay output control with forced operation and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "relay_defines.vh"
module relay_output (
	// Clock, reset, enable
	input wire core_clk,
	input wire rst_b,
	input wire ce,
	// Bus supply sense pin, high while supply is lost
	input wire bus_supply_loss,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Relay
	output reg contact_closed,
	output reg status_bit
);
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `ADDR_CONFIG) || (a == `ADDR_SWITCH) ||
				(a == `ADDR_FORCED) || (a == `ADDR_SUPPLY) ||
				(a == `ADDR_STATUS);
		end
	endfunction

	reg [`CFG_WIDTH-1:0] cfg;
	reg sw_obj;
	reg [1:0] forced_obj;
	reg force_on;
	reg hold_pending;
	reg loss_q;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg aw_held;
	reg w_held;
	wire loss_s;
	wire f_active;
	wire f_level;
	wire nc = cfg[`CFG_NC];
	wire [1:0] loss_sel = cfg[`CFG_LOSS_LO+1:`CFG_LOSS_LO];
	wire [1:0] rec_sel = cfg[`CFG_REC_LO+1:`CFG_REC_LO];
	wire [1:0] fpos = cfg[`CFG_FPOS_LO+1:`CFG_FPOS_LO];
	wire [1:0] fend = cfg[`CFG_FEND_LO+1:`CFG_FEND_LO];
	wire contact_on = contact_closed ^ nc;

	sync2 u_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.ce(ce),
		.d(bus_supply_loss),
		.q(loss_s)
	);

	forced_decode u_dec (
		.two_bit(cfg[`CFG_FTYPE]),
		.one_bit_pos(fpos),
		.value(forced_obj),
		.held_on(contact_on),
		.active(f_active),
		.level(f_level)
	);

	////////////////////////////////////////////////////////////////////////
	// Write channel
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire aw_now = aw_held || (s_axi_awvalid && s_axi_awready);
	wire w_now = w_held || (s_axi_wvalid && s_axi_wready);
	wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wd = w_held ? w_data : s_axi_wdata;
	wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
	wire do_wr = aw_now && w_now && !s_axi_bvalid;
	wire wr_cfg = do_wr && wa == `ADDR_CONFIG;
	wire wr_sw = do_wr && wa == `ADDR_SWITCH && ws[0];
	wire wr_f = do_wr && wa == `ADDR_FORCED && ws[0];

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				aw_held <= aw_now;
				w_held <= w_now;
				if (s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY
					: `RESP_SLVERR;
				case (s_axi_araddr)
				`ADDR_CONFIG: s_axi_rdata <= {21'h000000, cfg};
				`ADDR_SWITCH: s_axi_rdata <= {31'h00000000, sw_obj};
				`ADDR_FORCED: s_axi_rdata <= {30'h00000000, forced_obj};
				`ADDR_SUPPLY: s_axi_rdata <= {31'h00000000, loss_s};
				`ADDR_STATUS: s_axi_rdata <= {28'h0000000, f_active,
					hold_pending, status_bit, contact_closed};
				default: s_axi_rdata <= 32'h00000000;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Objects and contact
	wire loss_rise = loss_s && !loss_q;
	wire loss_fall = !loss_s && loss_q;
	wire f_end = force_on && !f_active;
	reg next_contact;
	reg next_hold;

	always @* begin
		next_contact = contact_closed;
		next_hold = hold_pending;
		if (loss_s) begin
			// Contact set by the loss selection at onset of loss, then frozen while supply is missing
			if (loss_rise) begin
				case (loss_sel)
				`LOSS_OPEN: next_contact = 1'b0;
				`LOSS_CLOSE: next_contact = 1'b1;
				default: next_contact = contact_closed;
				endcase
			end
		end else if (loss_fall) begin
			if (rec_sel == `REC_W0) begin
				next_contact = nc;
			end else if (rec_sel == `REC_W1) begin
				next_contact = !nc;
			end
			// Not-write waits for a new bus value
		end else if (force_on && f_active) begin
			next_contact = f_level ^ nc;
		end else if (f_end) begin
			case (fend)
			`FEND_ON: next_contact = !nc;
			`FEND_OFF: next_contact = nc;
			`FEND_CALC: next_contact = sw_obj ^ nc;
			default: next_hold = 1'b1;
			endcase
		end else if (!force_on && f_active) begin
			next_contact = f_level ^ nc;
		end else if (wr_sw) begin
			next_contact = wd[0] ^ nc;
			next_hold = 1'b0;
		end
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg <= `CFG_RESET;
			sw_obj <= 1'b0;
			forced_obj <= 2'h0;
			force_on <= 1'b0;
			hold_pending <= 1'b0;
			loss_q <= 1'b0;
			contact_closed <= 1'b0;
			status_bit <= 1'b0;
		end else if (ce) begin
			loss_q <= loss_s;
			contact_closed <= next_contact;
			hold_pending <= next_hold;
			status_bit <= next_contact ^ cfg[`CFG_INV];
			if (wr_cfg && ws[0]) begin
				cfg[7:0] <= wd[7:0];
			end
			if (wr_cfg && ws[1]) begin
				cfg[`CFG_WIDTH-1:8] <= wd[`CFG_WIDTH-1:8];
			end
			if (loss_fall) begin
				sw_obj <= (rec_sel == `REC_W1);
				forced_obj <= 2'h0;
				force_on <= 1'b0;
			end else if (!loss_s) begin
				force_on <= f_active;
				if (wr_sw) begin
					sw_obj <= wd[0];
				end
				if (wr_f) begin
					forced_obj <= wd[1:0];
				end
			end
		end
	end
endmodule
`default_nettype wire

// [relay_defines.vh]
// Constants for the relay output with forced operation
`ifndef RELAY_DEFINES_VH
`define RELAY_DEFINES_VH
`define ADDR_CONFIG 8'h00
`define ADDR_SWITCH 8'h04
`define ADDR_FORCED 8'h08
`define ADDR_SUPPLY 8'h0c
`define ADDR_STATUS 8'h10
// Config field positions
`define CFG_NC 0
`define CFG_LOSS_LO 1
`define CFG_REC_LO 3
`define CFG_FTYPE 5
`define CFG_FPOS_LO 6
`define CFG_FEND_LO 8
`define CFG_INV 10
`define CFG_WIDTH 11
`define CFG_RESET 11'h000
// Three-way and four-way selections, and AXI response codes
`define LOSS_UNCH 2'h0
`define LOSS_OPEN 2'h1
`define LOSS_CLOSE 2'h2
`define REC_NOWR 2'h0
`define REC_W0 2'h1
`define REC_W1 2'h2
`define FPOS_OFF 2'h0
`define FPOS_ON 2'h1
`define FPOS_UNCH 2'h2
`define FEND_ON 2'h0
`define FEND_OFF 2'h1
`define FEND_UNCH 2'h2
`define FEND_CALC 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [forced_decode.v]
// Decoder of the forced-operation object into force flag and level
`timescale 1ns/1ps
`default_nettype none
`include "relay_defines.vh"
module forced_decode (
	// Configuration
	input wire two_bit,
	input wire [1:0] one_bit_pos,
	// Object value and held switch level
	input wire [1:0] value,
	input wire held_on,
	// Decoded
	output reg active,
	output reg level
);
	always @* begin
		if (two_bit) begin
			active = value[1];
			level = value[0];
		end else begin
			active = value[0];
			case (one_bit_pos)
			`FPOS_ON: level = 1'b1;
			`FPOS_UNCH: level = held_on;
			default: level = 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

// [sync2.v]
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2 (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	input wire ce,
	// Level
	input wire d,
	output reg q
);
	reg meta;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// [relay_output_properties.sv]
// Port checker for the relay output
`timescale 1ns/1ps
`default_nettype none
module relay_output_properties (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic bus_supply_loss,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic contact_closed
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready && ce
		|=> s_axi_bvalid) else $error("bvalid dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready && ce
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read lost");
	wr_refuse_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("write taken");
	rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken");
	wr_answer_a: assert property (ce && s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("no write response");
	rd_unmapped_a: assert property (ce && s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > 8'h10 |=> s_axi_rvalid && s_axi_rresp == 2'h2
		&& s_axi_rdata == 32'h0) else $error("bad unmapped read");
	loss_freeze_a: assert property (bus_supply_loss [*6]
		|-> $stable(contact_closed)) else $error("contact moved");
	contact_cause_a: assert property ($changed(contact_closed)
		|-> s_axi_bvalid || $past(s_axi_bvalid) || $past(bus_supply_loss, 2)
		!= $past(bus_supply_loss, 4)) else $error("contact moved alone");
	reset_out_a: assert property (disable iff (1'b0) !rst_b
		|-> !contact_closed && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs set in reset");
endmodule
bind relay_output relay_output_properties chk (.*);
`default_nettype wire

// [supply_sense_model.sv]
// Model of the bus supply sense line
`timescale 1ns/1ps
`default_nettype none
module supply_sense_model (
	// Clock
	input wire logic core_clk,
	// Sense pin, held until changed
	output var logic bus_supply_loss
);
	initial bus_supply_loss = 1'b0;
	task automatic set_loss(input logic v);
		@(posedge core_clk);
		bus_supply_loss <= v;
	endtask
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the relay output
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 0, rst_b, ce = 1;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire logic s_axi_rvalid, contact_closed, status_bit, bus_supply_loss;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	int n_mismatch = 0, num_checks = 0;
	relay_output dut (.*);
	supply_sense_model src (
		.core_clk(core_clk),
		.bus_supply_loss(bus_supply_loss)
	);
	always #2 core_clk = ~core_clk;
	task automatic print_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (i = 0; i < 20 && s_axi_bvalid !== 1'b1; i++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end
		if (i == 20) begin
			n_mismatch++;
			print_verdict;
		end
		chk(32'(s_axi_bresp), (a <= 8'h10 && a[1:0] == 2'h0) ? 0 : 2);
		s_axi_bready <= 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int i;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (i = 0; i < 20 && s_axi_rvalid !== 1'b1; i++) begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		if (i == 20) begin
			n_mismatch++;
			print_verdict;
		end
		s_axi_rready <= 0;
		chk(s_axi_rdata, d);
		chk(32'(s_axi_rresp), 32'(r));
	endtask
	// Write, let a forced object settle, then look at the contact
	task automatic ws(input logic [7:0] a, input logic [31:0] d, input logic e);
		wr(a, d);
		repeat (2) @(posedge core_clk);
		chk(32'(contact_closed), 32'(e));
	endtask
	task automatic lp(input logic v, input logic e);
		src.set_loss(v);
		repeat (8) @(posedge core_clk);
		chk(32'(contact_closed), 32'(e));
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic s_pol;
		wr(8'h00, 32'h0);
		ws(8'h04, 1, 1);
		chk(32'(status_bit), 1);
		ws(8'h04, 0, 0);
		wr(8'h00, 32'h1);
		ws(8'h04, 0, 1);
		ws(8'h04, 1, 0);
		wr(8'h00, 32'h401);
		ws(8'h04, 1, 0);
		chk(32'(status_bit), 1);
	endtask
	task automatic s_two;
		wr(8'h00, 32'h20);
		ws(8'h04, 0, 0);
		ws(8'h08, 3, 1);
		ws(8'h04, 0, 1);
		ws(8'h08, 2, 0);
		ws(8'h04, 1, 0);
		ws(8'h08, 1, 1);
		wr(8'h00, 32'h120);
		ws(8'h08, 3, 1);
		ws(8'h08, 0, 0);
		ws(8'h04, 1, 1);
	endtask
	task automatic s_one;
		wr(8'h00, 32'h300);
		ws(8'h04, 1, 1);
		ws(8'h08, 1, 0);
		ws(8'h04, 1, 0);
		ws(8'h08, 0, 1);
		wr(8'h00, 32'h340);
		ws(8'h08, 1, 1);
		ws(8'h04, 0, 1);
		ws(8'h08, 0, 0);
		wr(8'h00, 32'h240);
		ws(8'h04, 0, 0);
		ws(8'h08, 1, 1);
		ws(8'h08, 0, 1);
		rdc(8'h10, 32'h7, 0);
		ws(8'h04, 0, 0);
		wr(8'h00, 32'h080);
		ws(8'h08, 1, 0);
		ws(8'h04, 1, 0);
		ws(8'h08, 0, 1);
	endtask
	task automatic s_loss;
		wr(8'h00, 32'hc);
		ws(8'h04, 0, 0);
		lp(1, 1);
		rdc(8'h0c, 1, 0);
		wr(8'h04, 1);
		lp(0, 0);
		rdc(8'h04, 0, 0);
		wr(8'h00, 32'h12);
		ws(8'h04, 1, 1);
		lp(1, 0);
		lp(0, 1);
		wr(8'h00, 32'h2);
		rdc(8'h00, 32'h2, 0);
		lp(1, 0);
		lp(0, 0);
		rdc(8'h04, 0, 0);
		ws(8'h04, 1, 1);
		wr(8'h00, 32'h0);
		lp(1, 1);
		lp(0, 1);
	endtask
	// Supply loss seen with the enable low must leave all state alone
	task automatic s_ce;
		wr(8'h00, 32'h2);
		ce <= 1'b0;
		lp(1, 1);
		lp(0, 1);
		ce <= 1'b1;
		rdc(8'h0c, 0, 0);
		chk(32'(contact_closed), 1);
	endtask
	initial begin
		rst_b <= 1'b0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1;
		s_pol;
		s_two;
		s_one;
		s_loss;
		s_ce;
		wr(8'h40, 0);
		rdc(8'h40, 0, 2);
		print_verdict;
	end
endmodule
`default_nettype wire
